// ==== design/dtm_monitor.sv ====
`timescale 1ns/1ps
module dtm_monitor
    import dtm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // pins
    input wire logic i_standby_select_n,
    input wire logic [1:0] i_addr_sel_low,
    input wire logic [1:0] i_addr_sel_high,
    output logic o_alert_oe,
    output logic [6:0] o_dev_addr,
    // analog front end
    input wire dtm_adc_t i_adc,
    output logic o_adc_start,
    output logic o_adc_remote,
    // interrupt
    output logic o_irq
);
    dtm_regs_t q, d;
    logic [4:0] pins_s;
    logic standby;
    logic [4:0] cond;
    logic [11:0] acc_next;
    logic [7:0] avg;
    logic [11:0] interval;
    logic [4:0] stat_clr;
    logic [1:0] irq_ev;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    dtm_sync #(.W(5)) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_standby_select_n, i_addr_sel_high, i_addr_sel_low}),
        .o_sync(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // live limit conditions, signed compare of stored values
    always_comb begin
        cond[FLAG_LHI] = $signed(q.local_val) > $signed(q.lhi);
        cond[FLAG_LLO] = $signed(q.local_val) < $signed(q.llo);
        cond[FLAG_RHI] = $signed(q.remote_val) > $signed(q.rhi);
        cond[FLAG_RLO] = $signed(q.remote_val) < $signed(q.rlo);
        cond[FLAG_OPEN] = q.open_c;
    end

    // sixteen-sample running sum, result is sum divided by sixteen
    assign acc_next = q.acc + {{4{i_adc.data[7]}}, i_adc.data};
    assign avg = acc_next[11:4];
    // pin low or config bit selects standby
    assign standby = !pins_s[4] || q.cfg[CFG_STANDBY_BIT];
    // interval in ms halves per rate code, codes above 7 act as 7
    assign interval = 12'(INTERVAL_BASE_MS >> ((q.rate > 8'h07) ? 3'h7 : q.rate[2:0]));

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        d = q;
        d.adc_start = 1'b0;
        d.cmp = 1'b0;
        irq_ev = 2'b00;
        stat_clr = 5'h00;
        // address straps, three levels each: low, float, high
        d.addr = {ADDR_BASE[6:4], pins_s[3:2], pins_s[1:0]};
        // millisecond time base and interval counter
        if (q.ms_cnt == 15'(TICK_CYCLES - 1)) begin
            d.ms_cnt = '0;
            if (q.int_cnt != 12'hFFF) begin
                d.int_cnt = q.int_cnt + 12'h001;
            end
        end else begin
            d.ms_cnt = q.ms_cnt + 15'h0001;
        end
        // power-up compare of defaults when starting in standby
        if (q.boot != 2'h3) begin
            d.boot = q.boot + 2'h1;
            if (q.boot == 2'h2 && standby) begin
                d.cmp = 1'b1;
            end
        end
        // conversion sequencer
        unique case (q.st)
            ST_IDLE: begin
                if (q.boot == 2'h3 && ((!standby && q.int_cnt >= interval) || q.one_shot)) begin
                    d.st = ST_START;
                    d.int_cnt = '0;
                    d.one_shot = 1'b0;
                    d.chan = 1'b0;
                    d.cnt = '0;
                    d.acc = '0;
                end
            end
            ST_START: begin
                d.adc_start = 1'b1;
                d.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (i_adc.done) begin
                    d.acc = acc_next;
                    d.cnt = q.cnt + 4'h1;
                    d.st = ST_START;
                    if (q.chan) begin
                        d.open_c = i_adc.open;
                    end
                    if (q.cnt == 4'(AVG_COUNT - 1)) begin
                        d.acc = '0;
                        if (!q.chan) begin
                            d.local_val = avg;
                            d.chan = 1'b1;
                        end else begin
                            d.remote_val = avg;
                            d.chan = 1'b0;
                            d.st = ST_IDLE;
                            d.seen_pair = 1'b1;
                            d.cmp = 1'b1;
                            irq_ev[IRQ_PAIR_DONE] = 1'b1;
                        end
                    end
                end
            end
        endcase
        // register reads, answer one cycle later
        d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                REG_LOCAL_VAL: d.rdata = q.local_val;
                REG_REMOTE_VAL: d.rdata = q.remote_val;
                REG_STATUS: begin
                    d.rdata = {q.st != ST_IDLE, q.flags, 2'b00};
                    stat_clr = q.flags & ~cond;
                end
                REG_CFG_RD: d.rdata = q.cfg;
                REG_RATE_RD: d.rdata = q.rate;
                REG_LHI_RD: d.rdata = q.lhi;
                REG_LLO_RD: d.rdata = q.llo;
                REG_RHI_RD: d.rdata = q.rhi;
                REG_RLO_RD: d.rdata = q.rlo;
                REG_IRQ_STATUS: d.rdata = {6'h00, q.irq_st};
                REG_IRQ_MASK: d.rdata = {6'h00, q.irq_mask};
                default: d.rdata = 8'h00;
            endcase
        end
        // register writes
        if (i_wr) begin
            unique case (i_addr)
                REG_CFG_WR: d.cfg = i_wdata;
                REG_RATE_WR: d.rate = i_wdata;
                REG_LHI_WR: d.lhi = i_wdata;
                REG_LLO_WR: d.llo = i_wdata;
                REG_RHI_WR: d.rhi = i_wdata;
                REG_RLO_WR: d.rlo = i_wdata;
                REG_ONE_SHOT: d.one_shot = 1'b1;
                REG_IRQ_MASK: d.irq_mask = i_wdata[1:0];
                default: d.cfg = d.cfg;
            endcase
        end
        // flags: set by a compare wins over the read clear
        if (q.cmp && |cond) begin
            irq_ev[IRQ_LIMIT] = 1'b1;
        end
        d.flags = (q.flags & ~stat_clr) | (q.cmp ? cond : 5'h00);
        // sticky interrupt status, write one clears, event wins
        d.irq_st = q.irq_st;
        if (i_wr && i_addr == REG_IRQ_STATUS) begin
            d.irq_st = q.irq_st & ~i_wdata[1:0];
        end
        d.irq_st = d.irq_st | irq_ev;
        d.irq = |(q.irq_st & q.irq_mask);
        // open-drain alarm: only the enable is driven, the pin is never driven high
        d.alert_oe = |q.flags && !q.cfg[CFG_MASK_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.local_val <= RST_VALUE;
            q.remote_val <= RST_VALUE;
            q.cfg <= RST_CFG;
            q.rate <= RST_RATE;
            q.lhi <= RST_HI_LIMIT;
            q.llo <= RST_LO_LIMIT;
            q.rhi <= RST_HI_LIMIT;
            q.rlo <= RST_LO_LIMIT;
            q.int_cnt <= 12'hFFF;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign o_rdata = q.rdata;
    assign o_alert_oe = q.alert_oe;
    assign o_dev_addr = q.addr;
    assign o_adc_start = q.adc_start;
    assign o_adc_remote = q.chan;
    assign o_irq = q.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_last_local;
        q.st == ST_WAIT && i_adc.done && q.cnt == 4'hF && !q.chan;
    endsequence
    sequence s_last_remote;
        q.st == ST_WAIT && i_adc.done && q.cnt == 4'hF && q.chan;
    endsequence

    a_alert_on_flag: assert property (
        (q.cmp && |cond && !q.cfg[CFG_MASK_BIT] && !i_wr) |=> ##1 o_alert_oe)
        else $error("alarm not driven with a flag set");
    a_mask_blocks_alert: assert property (
        q.cfg[CFG_MASK_BIT] |=> !o_alert_oe)
        else $error("alarm driven while masked");
    a_local_store: assert property (
        s_last_local |=> q.local_val == $past(avg) && q.chan)
        else $error("local average not stored");
    a_pair_compare: assert property (
        s_last_remote |=> q.cmp ##1 (q.flags & $past(cond)) == $past(cond))
        else $error("pair end did not set flags");
    a_value_default: assert property (
        !q.seen_pair |-> q.remote_val == RST_VALUE && (q.chan || q.local_val == RST_VALUE))
        else $error("value changed before first pair");
    a_standby_quiet: assert property (
        (q.st == ST_IDLE && standby && !q.one_shot) |=> q.st == ST_IDLE)
        else $error("conversion began in standby");
    a_flag_persists: assert property (
        (i_rd && i_addr == REG_STATUS && q.flags[FLAG_LLO] && cond[FLAG_LLO]) |=> q.flags[FLAG_LLO])
        else $error("flag cleared while cause persists");
    a_status_busy: assert property (
        (i_rd && i_addr == REG_STATUS) |=> o_rdata[7] == ($past(q.st) != ST_IDLE) && o_rdata[1:0] == 2'b00)
        else $error("status busy or reserved bits wrong");
    a_boot_standby: assert property (
        (q.boot == 2'h2 && standby && q.lhi == RST_HI_LIMIT && q.llo == RST_LO_LIMIT
         && q.rlo == RST_LO_LIMIT && !q.seen_pair) |=> ##1 q.flags[FLAG_LLO] && q.flags[FLAG_RLO])
        else $error("standby power-up alarm missing");
    a_irq_level: assert property (
        |(q.irq_st & q.irq_mask) |=> o_irq)
        else $error("interrupt output low with unmasked status");

    // status read with no compare landing in the same cycle
    sequence s_plain_status_read;
        i_rd && i_addr == REG_STATUS && !q.cmp;
    endsequence

    // conversion sequencing
    a_start_pulse: assert property (
        o_adc_start |=> !o_adc_start)
        else $error("start request longer than one cycle");
    a_start_follows: assert property (
        q.st == ST_START |=> o_adc_start && q.st == ST_WAIT)
        else $error("start state did not request a sample");
    a_pair_ends_idle: assert property (
        s_last_remote |=> !o_adc_remote && q.st == ST_IDLE)
        else $error("pair end did not return to local and idle");
    a_sixteen_samples: assert property (
        (q.st == ST_WAIT && i_adc.done) |=> q.cnt == $past(q.cnt) + 4'h1)
        else $error("sample count did not advance");

    // stored values change only at the end of a channel
    a_remote_store: assert property (
        s_last_remote |=> q.remote_val == $past(avg))
        else $error("remote average not stored");
    a_value_hold: assert property (
        !(q.st == ST_WAIT && i_adc.done && q.cnt == 4'hF) |=> $stable(q.local_val) && $stable(q.remote_val))
        else $error("value register changed mid average");

    // compare, flags and alarm
    a_limit_irq: assert property (
        (q.cmp && |cond) |=> q.irq_st[IRQ_LIMIT])
        else $error("limit event not recorded");
    a_flags_from_cmp: assert property (
        !q.cmp |=> (q.flags & ~$past(q.flags)) == 5'h00)
        else $error("flag set without a compare");
    a_no_early_cmp: assert property (
        (q.boot == 2'h2 && !standby) |=> !q.cmp)
        else $error("compare before first pair in converting boot");
    a_open_drain: assert property (
        !(|q.flags) |=> !o_alert_oe)
        else $error("alarm driven with no flag set");
    a_read_clears: assert property (
        s_plain_status_read |=> q.flags == ($past(q.flags) & $past(cond)))
        else $error("status read cleared the wrong flags");
    a_low_clear: assert property (
        s_plain_status_read ##0 (!cond[FLAG_LLO] && !cond[FLAG_RLO])
            |=> !q.flags[FLAG_LLO] && !q.flags[FLAG_RLO])
        else $error("low flags kept after limits lowered");

    // register port and settings
    a_rdata_idle: assert property (
        !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_value_read: assert property (
        (i_rd && i_addr == REG_REMOTE_VAL) |=> o_rdata == $past(q.remote_val))
        else $error("remote value read back wrong");
    a_limit_write: assert property (
        (i_wr && i_addr == REG_LHI_WR) |=> q.lhi == $past(i_wdata))
        else $error("high limit write lost");
    a_cfg_write: assert property (
        (i_wr && i_addr == REG_CFG_WR) |=> q.cfg == $past(i_wdata))
        else $error("configuration write lost");
    a_rate_hold: assert property (
        (q.st == ST_IDLE && q.boot == 2'h3 && !q.one_shot && q.int_cnt < interval) |=> q.st == ST_IDLE)
        else $error("conversion began before the interval ran out");
    a_addr_straps: assert property (
        1'b1 |=> o_dev_addr == {ADDR_BASE[6:4], $past(pins_s[3:2]), $past(pins_s[1:0])})
        else $error("device address does not follow straps");
endmodule

// ==== design/dtm_pkg.sv ====
package dtm_pkg;
    // register offsets, read side
    localparam logic [7:0] REG_LOCAL_VAL = 8'h00;
    localparam logic [7:0] REG_REMOTE_VAL = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_CFG_RD = 8'h03;
    localparam logic [7:0] REG_RATE_RD = 8'h04;
    localparam logic [7:0] REG_LHI_RD = 8'h05;
    localparam logic [7:0] REG_LLO_RD = 8'h06;
    localparam logic [7:0] REG_RHI_RD = 8'h07;
    localparam logic [7:0] REG_RLO_RD = 8'h08;
    // register offsets, write side
    localparam logic [7:0] REG_CFG_WR = 8'h09;
    localparam logic [7:0] REG_RATE_WR = 8'h0A;
    localparam logic [7:0] REG_LHI_WR = 8'h0B;
    localparam logic [7:0] REG_LLO_WR = 8'h0C;
    localparam logic [7:0] REG_RHI_WR = 8'h0D;
    localparam logic [7:0] REG_RLO_WR = 8'h0E;
    localparam logic [7:0] REG_ONE_SHOT = 8'h0F;
    // interrupt block
    localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h21;
    // reset values
    localparam logic [7:0] RST_VALUE = 8'h80;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h02;
    localparam logic [7:0] RST_HI_LIMIT = 8'h7F;
    localparam logic [7:0] RST_LO_LIMIT = 8'hC9;
    // field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int STAT_BUSY_BIT = 7;
    localparam int FLAG_LHI = 4;
    localparam int FLAG_LLO = 3;
    localparam int FLAG_RHI = 2;
    localparam int FLAG_RLO = 1;
    localparam int FLAG_OPEN = 0;
    localparam int IRQ_PAIR_DONE = 0;
    localparam int IRQ_LIMIT = 1;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int INTERVAL_BASE_MS = 4000;
    localparam int AVG_COUNT = 16;
    localparam logic [6:0] ADDR_BASE = 7'h10;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} dtm_state_t;

    // measurement answer from the analog front end
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic open;
    } dtm_adc_t;

    typedef struct packed {
        dtm_state_t st;
        logic chan;
        logic [3:0] cnt;
        logic [11:0] acc;
        logic [7:0] local_val;
        logic [7:0] remote_val;
        logic [7:0] cfg;
        logic [7:0] rate;
        logic [7:0] lhi;
        logic [7:0] llo;
        logic [7:0] rhi;
        logic [7:0] rlo;
        logic [4:0] flags;
        logic open_c;
        logic cmp;
        logic one_shot;
        logic [1:0] boot;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic [7:0] rdata;
        logic alert_oe;
        logic irq;
        logic adc_start;
        logic [6:0] addr;
        logic [14:0] ms_cnt;
        logic [11:0] int_cnt;
        logic seen_pair;
    } dtm_regs_t;
endpackage

// ==== design/dtm_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module dtm_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ==== verification/dtm_afe_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// behavioural analog front end: answers each start with one sample
module dtm_afe_model
    import dtm_pkg::*;
(
    // clock and request
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic i_remote,
    // scene set by the bench
    input wire logic [7:0] i_local_t,
    input wire logic [7:0] i_remote_t,
    input wire logic i_open,
    input wire logic i_slow,
    // answer
    output dtm_adc_t o_adc
);
    int wait_q = -1;
    int idx_q = 0;
    logic chan_q = 1'b0;

    initial o_adc = '0;

    ////////////////////////////////////////////////////////////////////////
    // data shows junk outside done, so a stale byte never passes for a sample
    always @(posedge i_clk) begin
        o_adc.done <= 1'b0;
        o_adc.data <= ~o_adc.data;
        if (i_start) begin
            wait_q <= i_slow ? 9 : 1;
            chan_q <= i_remote;
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end else if (wait_q == 0) begin
            wait_q <= -1;
            idx_q <= idx_q + 1;
            o_adc.done <= 1'b1;
            o_adc.open <= chan_q & i_open;
            // noise -1..+2 sums to +8 over any 16 samples, so the mean floors to the base
            o_adc.data <= (chan_q ? i_remote_t : i_local_t) + 8'(idx_q % 4) - 8'h01;
        end
    end
endmodule

// ==== verification/dtm_monitor_tb_top.sv ====
`timescale 1ns/1ps
module dtm_monitor_tb_top
    import dtm_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_standby_select_n = 1'b0;
    logic [1:0] i_addr_sel_low = 2'h0;
    logic [1:0] i_addr_sel_high = 2'h0;
    logic [7:0] local_t = 8'h00;
    logic [7:0] remote_t = 8'h00;
    logic open_c = 1'b0;
    logic slow = 1'b0;
    dtm_adc_t adc;
    logic [7:0] o_rdata;
    logic [6:0] o_dev_addr;
    logic o_alert_oe, o_adc_start, o_adc_remote, o_irq;
    int failures = 0;
    int samples_checked = 0;
    int n_starts = 0;
    int seed = 11100;
    int lt, rt, s0;
    logic [7:0] rst_tab [0:8] = '{8'h80, 8'h80, 8'h28, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};

    // short tick keeps each conversion pair to a few hundred cycles
    dtm_monitor #(.TICK_CYCLES(4)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_standby_select_n(i_standby_select_n),
        .i_addr_sel_low(i_addr_sel_low), .i_addr_sel_high(i_addr_sel_high), .o_alert_oe(o_alert_oe),
        .o_dev_addr(o_dev_addr), .i_adc(adc), .o_adc_start(o_adc_start), .o_adc_remote(o_adc_remote),
        .o_irq(o_irq));
    dtm_afe_model afe (.i_clk(i_clk), .i_start(o_adc_start), .i_remote(o_adc_remote), .i_local_t(local_t),
        .i_remote_t(remote_t), .i_open(open_c), .i_slow(slow), .o_adc(adc));

    ////////////////////////////////////////////////////////////////////////
    // clock and start counter
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_adc_start === 1'b1) n_starts <= n_starts + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, taken at the edge that closes it
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        chk(o_rdata & m, e);
    endtask
    task automatic do_reset();
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
    endtask
    // irq falls a cycle late, so skip two edges before polling
    task automatic wait_irq();
        int n;
        n = 0;
        repeat (2) @(posedge i_clk);
        while (o_irq !== 1'b1 && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 3000) begin
            failures++;
            wrap_up();
        end
        repeat (3) @(posedge i_clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        // straps are sensed after each boot; the last boot stays in standby
        for (int h = 0; h < 3; h++) begin
            for (int l = 0; l < 3; l++) begin
                i_addr_sel_high <= 2'(h);
                i_addr_sel_low <= 2'(l);
                do_reset();
                repeat (8) @(posedge i_clk);
                chk({1'b0, o_dev_addr}, {1'b0, ADDR_BASE[6:4], 2'(h), 2'(l)});
            end
        end
        chk({7'h00, o_alert_oe}, 8'h01);
        for (int i = 0; i < 9; i++) begin
            rd(8'(i), 8'hFF, rst_tab[i]);
        end
        rd(8'h30, 8'hFF, 8'h00);
        // lowering both low limits lets a status read clear the alarm
        wr(REG_LLO_WR, 8'h80);
        wr(REG_RLO_WR, 8'h80);
        rd(REG_STATUS, 8'hFF, 8'h28);
        rd(REG_STATUS, 8'hFF, 8'h00);
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_alert_oe}, 8'h00);
        // converting: averaged values land in both value registers
        lt = 10 + ($unsigned($random(seed)) % 80);
        rt = 10 + ($unsigned($random(seed)) % 80);
        local_t <= 8'(lt);
        remote_t <= 8'(rt);
        i_standby_select_n <= 1'b1;
        wr(REG_RATE_WR, 8'h07);
        wr(REG_IRQ_STATUS, 8'h03);
        wr(REG_IRQ_MASK, 8'h03);
        wait_irq();
        rd(REG_IRQ_STATUS, 8'hFF, 8'h01);
        rd(REG_LOCAL_VAL, 8'hFF, 8'(lt));
        rd(REG_REMOTE_VAL, 8'hFF, 8'(rt));
        // local high limit one below the reading trips the flag
        wr(REG_LHI_WR, 8'(lt - 1));
        wr(REG_IRQ_STATUS, 8'h03);
        wait_irq();
        chk({7'h00, o_alert_oe}, 8'h01);
        rd(REG_IRQ_STATUS, 8'hFF, 8'h03);
        rd(REG_STATUS, 8'h7F, 8'h40);
        rd(REG_STATUS, 8'h7F, 8'h40);
        wr(REG_CFG_WR, 8'h80);
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_alert_oe}, 8'h00);
        rd(REG_CFG_RD, 8'hFF, 8'h80);
        // cause gone: the sticky flag clears on the first read only
        wr(REG_LHI_WR, 8'h7F);
        wr(REG_CFG_WR, 8'h00);
        wr(REG_IRQ_STATUS, 8'h03);
        wait_irq();
        rd(REG_STATUS, 8'h7F, 8'h40);
        rd(REG_STATUS, 8'h7F, 8'h00);
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_alert_oe}, 8'h00);
        // open remote sensor keeps its flag across reads
        open_c <= 1'b1;
        wr(REG_IRQ_STATUS, 8'h03);
        wait_irq();
        rd(REG_STATUS, 8'h7F, 8'h04);
        rd(REG_STATUS, 8'h7F, 8'h04);
        open_c <= 1'b0;
        // pin standby, then software standby, with a slow front end
        slow <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            if (m == 0) i_standby_select_n <= 1'b0;
            else wr(REG_CFG_WR, 8'h40);
            repeat (800) @(posedge i_clk);
            s0 = n_starts;
            repeat (600) @(posedge i_clk);
            chk(8'(n_starts - s0), 8'h00);
            i_standby_select_n <= 1'b1;
        end
        // converting boot: no compare before both values are stored
        slow <= 1'b0;
        do_reset();
        repeat (40) @(posedge i_clk);
        chk({7'h00, o_alert_oe}, 8'h00);
        rd(REG_LOCAL_VAL, 8'hFF, 8'h80);
        repeat (400) @(posedge i_clk);
        rd(REG_LOCAL_VAL, 8'hFF, 8'(lt));
        rd(REG_REMOTE_VAL, 8'hFF, 8'(rt));
        chk({7'h00, o_alert_oe}, 8'h00);
        // standby boot left by the pin: in-limit values let a status read clear the alarm
        i_standby_select_n <= 1'b0;
        do_reset();
        repeat (8) @(posedge i_clk);
        chk({7'h00, o_alert_oe}, 8'h01);
        i_standby_select_n <= 1'b1;
        wr(REG_IRQ_MASK, 8'h01);
        wait_irq();
        rd(REG_STATUS, 8'h7F, 8'h28);
        rd(REG_STATUS, 8'h7F, 8'h00);
        repeat (3) @(posedge i_clk);
        chk({7'h00, o_alert_oe}, 8'h00);
        wrap_up();
    end

    // watchdog against a hang anywhere in the sequence
    initial begin
        repeat (50000) @(posedge i_clk);
        failures++;
        wrap_up();
    end
endmodule
